// *** src/sce_pkg.sv ***
// Shared constants and carriers for the system-control event and gating block.
// Assumes a 32-bit APB register bus and one clock domain.
package sce_pkg;
    // ----------------------------------------
    // Register byte offsets
    // ----------------------------------------
    localparam logic [11:0] RAW_OFS     = 12'h000;
    localparam logic [11:0] ENABLE_OFS  = 12'h004;
    localparam logic [11:0] MASKED_OFS  = 12'h008;
    localparam logic [11:0] CLEAR_OFS   = 12'h00c;
    localparam logic [11:0] ENSET_OFS   = 12'h010;
    localparam logic [11:0] ENCLR_OFS   = 12'h014;
    localparam logic [11:0] PORTBUS_OFS = 12'h018;
    localparam logic [11:0] REG_OFS     = 12'h01c;
    localparam logic [11:0] GATE_OFS    = 12'h020;
    localparam logic [11:0] SLEEP_OFS   = 12'h024;
    localparam logic [11:0] DEEP_OFS    = 12'h028;
    localparam logic [11:0] FLASH_OFS   = 12'h02c;

    // ----------------------------------------
    // Event bit positions
    // ----------------------------------------
    localparam int EV_COUNT              = 7;
    localparam int SYNTH_LOCKED_EVENT    = 0;
    localparam int CURRENT_LIMIT_EVENT   = 1;
    localparam int INTERNAL_OSC_FAIL_EVENT = 2;
    localparam int MAIN_OSC_FAIL_EVENT   = 3;
    localparam int POWER_ON_EVENT        = 4;
    localparam int BROWNOUT_EVENT        = 5;
    localparam int SYNTH_FAIL_EVENT      = 6;

    // ----------------------------------------
    // Regulator codes: 2.25 V + 50 mV per step
    // ----------------------------------------
    localparam logic [3:0] REGULATOR_MIN_SETTING = 4'h0;
    localparam logic [3:0] REGULATOR_DEFAULT     = 4'h5;
    localparam logic [3:0] REGULATOR_MAX_SETTING = 4'ha;

    localparam logic [6:0] ENABLE_RESET = 7'h00;
    localparam logic       GATE_RESET   = 1'b0;

    // ----------------------------------------
    // Power mode and carrier
    // ----------------------------------------
    typedef enum logic [2:0] {
        SCE_RUN   = 3'b001,
        SCE_SLEEP = 3'b010,
        SCE_DEEP  = 3'b100
    } sce_mode_e;

    typedef struct packed {
        logic [11:0] addr;
        logic        write;
        logic [31:0] wdata;
    } sce_req_s;
endpackage : sce_pkg

// *** src/sce_top.sv ***
// System-control event sources, interrupt, port bus select, regulator and clock gating.
// Assumes APB master on ref_clk; event inputs are synchronous one-cycle or level pulses.
//
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/100ps
module sce_top #(
    parameter int          PORTS      = 8,
    parameter int          PERIPHS    = 32,
    parameter logic [31:0] FLASH_BYTES = 32'h0004_0000
) (
    input  wire  logic                ref_clk,
    input  wire  logic                reset_n,
    input  wire  logic                psel,
    input  wire  logic                penable,
    input  wire  logic                pwrite,
    input  wire  logic [11:0]         paddr,
    input  wire  logic [31:0]         pwdata,
    output logic                      pready,
    output logic [31:0]               prdata,
    output logic                      pslverr,
    input  wire  logic [6:0]          event_in,
    input  wire  logic [1:0]          power_mode,
    input  wire  logic [PERIPHS-1:0]  run_clock_en,
    output logic                      sys_irq,
    output logic [PORTS-1:0]          port_fast_bus,
    output logic [3:0]                regulator_setting,
    output logic [PERIPHS-1:0]        periph_clock_en
);
    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    sce_pkg::sce_req_s req;
    sce_pkg::sce_mode_e mode;
    logic [6:0]         raw;
    logic [6:0]         enable;
    logic               gate_on;
    logic [PERIPHS-1:0] sleep_mask;
    logic [PERIPHS-1:0] deep_mask;
    logic [31:0]        next_rdata;
    logic               next_err;

    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
    wire access = psel && penable && !pready;
    wire wr     = access && req.write;

    function automatic logic hit(input logic [11:0] ofs);
        hit = wr && (req.addr == ofs);
    endfunction : hit

    wire        wr_clear   = hit(sce_pkg::CLEAR_OFS);
    wire        wr_enable  = hit(sce_pkg::ENABLE_OFS);
    wire        wr_enset   = hit(sce_pkg::ENSET_OFS);
    wire        wr_enclr   = hit(sce_pkg::ENCLR_OFS);
    wire        wr_port    = hit(sce_pkg::PORTBUS_OFS);
    wire        wr_reg     = hit(sce_pkg::REG_OFS);
    wire        wr_gate    = hit(sce_pkg::GATE_OFS);
    wire        wr_sleep   = hit(sce_pkg::SLEEP_OFS);
    wire        wr_deep    = hit(sce_pkg::DEEP_OFS);
    wire [6:0]  wmask      = req.wdata[6:0];
    wire [3:0]  reg_code   = req.wdata[3:0];
    wire        reg_ok     = reg_code <= sce_pkg::REGULATOR_MAX_SETTING;
    wire [6:0]  masked     = raw & enable;
    wire [6:0]  next_raw   = (raw & ~(wr_clear ? wmask : 7'h00)) | event_in;

    wire [6:0]  next_enable = wr_enable ? wmask :
                              wr_enset  ? (enable | wmask) :
                              wr_enclr  ? (enable & ~wmask) : enable;

    assign mode = (power_mode == 2'h2) ? sce_pkg::SCE_DEEP :
                  (power_mode == 2'h1) ? sce_pkg::SCE_SLEEP : sce_pkg::SCE_RUN;

    logic [PERIPHS-1:0] next_clk;
    always_comb
    begin
        case (mode)
            sce_pkg::SCE_SLEEP: next_clk = gate_on ? (run_clock_en & sleep_mask) : run_clock_en;
            sce_pkg::SCE_DEEP:  next_clk = gate_on ? (run_clock_en & deep_mask) : run_clock_en;
            default:            next_clk = run_clock_en;
        endcase
    end

    always_comb
    begin
        next_err   = 1'b0;
        next_rdata = 32'h0000_0000;
        case (req.addr)
            sce_pkg::RAW_OFS:     next_rdata = {25'h0, raw};
            sce_pkg::ENABLE_OFS:  next_rdata = {25'h0, enable};
            sce_pkg::MASKED_OFS:  next_rdata = {25'h0, masked};
            sce_pkg::CLEAR_OFS:   next_rdata = 32'h0000_0000;
            sce_pkg::ENSET_OFS:   next_rdata = {25'h0, enable};
            sce_pkg::ENCLR_OFS:   next_rdata = {25'h0, enable};
            sce_pkg::PORTBUS_OFS: next_rdata = 32'(port_fast_bus);
            sce_pkg::REG_OFS:     next_rdata = {28'h0, regulator_setting};
            sce_pkg::GATE_OFS:    next_rdata = {31'h0, gate_on};
            sce_pkg::SLEEP_OFS:   next_rdata = 32'(sleep_mask);
            sce_pkg::DEEP_OFS:    next_rdata = 32'(deep_mask);
            sce_pkg::FLASH_OFS:   next_rdata = FLASH_BYTES;
            default:              next_err   = 1'b1;
        endcase
        if (req.addr == sce_pkg::FLASH_OFS && req.write)
            next_err = 1'b1;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= access;
            prdata  <= (access && !req.write) ? next_rdata : 32'h0000_0000;
            pslverr <= access && next_err;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            raw    <= 7'h00;
            enable <= sce_pkg::ENABLE_RESET;
            sys_irq <= 1'b0;
        end
        else
        begin
            raw     <= next_raw;
            enable  <= next_enable;
            sys_irq <= |(next_raw & next_enable);
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            port_fast_bus     <= '0;
            regulator_setting <= sce_pkg::REGULATOR_DEFAULT;
        end
        else
        begin
            if (wr_port)
                port_fast_bus <= req.wdata[PORTS-1:0];
            if (wr_reg && reg_ok)
                regulator_setting <= reg_code;
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gate_on         <= sce_pkg::GATE_RESET;
            sleep_mask      <= '0;
            deep_mask       <= '0;
            periph_clock_en <= '0;
        end
        else
        begin
            if (wr_gate)
                gate_on <= req.wdata[0];
            if (wr_sleep)
                sleep_mask <= req.wdata[PERIPHS-1:0];
            if (wr_deep)
                deep_mask <= req.wdata[PERIPHS-1:0];
            periph_clock_en <= next_clk;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_irq_cause: assert property (@(posedge ref_clk) disable iff (!reset_n)
        sys_irq == |(raw & enable))
        else $error("interrupt differs from enabled raw status");
    chk_raw_sticky: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (!wr_clear && raw[0]) |=> raw[0])
        else $error("raw event dropped without clear");
    chk_event_set: assert property (@(posedge ref_clk) disable iff (!reset_n)
        event_in[6] |=> raw[6])
        else $error("event did not set raw status");
    chk_clear_sel: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (wr_clear && wmask[1] && !event_in[1]) |=> !raw[1])
        else $error("clear did not deassert source");
    chk_clear_keep: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (wr_clear && !wmask[2] && raw[2]) |=> raw[2])
        else $error("clear touched unselected source");
    chk_enset_keep: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (wr_enset && enable[3]) |=> enable[3])
        else $error("enable set lost another source");
    chk_disabled_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (enable == 7'h00) |=> (enable != 7'h00 || !sys_irq))
        else $error("disabled sources raised interrupt");
    chk_reg_range: assert property (@(posedge ref_clk) disable iff (!reset_n)
        regulator_setting <= sce_pkg::REGULATOR_MAX_SETTING)
        else $error("regulator code out of range");
    chk_gate_off: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !gate_on |=> periph_clock_en == $past(run_clock_en))
        else $error("clocks gated while gating off");
    chk_fast_bus: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_port |=> port_fast_bus == $past(req.wdata[PORTS-1:0]))
        else $error("port bus select not stored");

    // ----------------------------------------
    // Bus transfer steps
    // ----------------------------------------
    sequence bus_taken;
        psel && penable && !pready;
    endsequence

    sequence read_taken;
        bus_taken ##0 !pwrite;
    endsequence

    chk_bus_answer: assert property (@(posedge ref_clk) disable iff (!reset_n)
        bus_taken |=> pready)
        else $error("access not answered after one wait state");
    chk_ready_once: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pready |=> !pready)
        else $error("ready held longer than one cycle");
    chk_read_idle: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data shown outside an answer");
    chk_raw_view: assert property (@(posedge ref_clk) disable iff (!reset_n)
        read_taken ##0 (req.addr == sce_pkg::RAW_OFS) |=> prdata == {25'h0, $past(raw)})
        else $error("raw view read wrong");
    chk_masked_view: assert property (@(posedge ref_clk) disable iff (!reset_n)
        read_taken ##0 (req.addr == sce_pkg::MASKED_OFS) |=> prdata == {25'h0, $past(raw & enable)})
        else $error("masked view read wrong");
    chk_enable_view: assert property (@(posedge ref_clk) disable iff (!reset_n)
        read_taken ##0 (req.addr == sce_pkg::ENABLE_OFS) |=> prdata == {25'h0, $past(enable)})
        else $error("enable mask read wrong");
    chk_clear_view: assert property (@(posedge ref_clk) disable iff (!reset_n)
        read_taken ##0 (req.addr == sce_pkg::CLEAR_OFS) |=> prdata == 32'h0000_0000)
        else $error("clear register read not zero");
    chk_port_view: assert property (@(posedge ref_clk) disable iff (!reset_n)
        read_taken ##0 (req.addr == sce_pkg::PORTBUS_OFS) |=> prdata == 32'($past(port_fast_bus)))
        else $error("port bus select read wrong");
    chk_reg_view: assert property (@(posedge ref_clk) disable iff (!reset_n)
        read_taken ##0 (req.addr == sce_pkg::REG_OFS) |=> prdata == {28'h0, $past(regulator_setting)})
        else $error("regulator read differs from held field");
    chk_gate_view: assert property (@(posedge ref_clk) disable iff (!reset_n)
        read_taken ##0 (req.addr == sce_pkg::GATE_OFS) |=> prdata == {31'h0, $past(gate_on)})
        else $error("gating bit read wrong");
    chk_sleep_view: assert property (@(posedge ref_clk) disable iff (!reset_n)
        read_taken ##0 (req.addr == sce_pkg::SLEEP_OFS) |=> prdata == 32'($past(sleep_mask)))
        else $error("sleep mask read wrong");
    chk_deep_view: assert property (@(posedge ref_clk) disable iff (!reset_n)
        read_taken ##0 (req.addr == sce_pkg::DEEP_OFS) |=> prdata == 32'($past(deep_mask)))
        else $error("deep-sleep mask read wrong");
    chk_flash_view: assert property (@(posedge ref_clk) disable iff (!reset_n)
        read_taken ##0 (req.addr == sce_pkg::FLASH_OFS) |=> prdata == FLASH_BYTES)
        else $error("flash size read wrong");
    chk_flash_locked: assert property (@(posedge ref_clk) disable iff (!reset_n)
        bus_taken ##0 (pwrite && req.addr == sce_pkg::FLASH_OFS) |=> pslverr)
        else $error("write to flash size not refused");

    // ----------------------------------------
    // Event and enable state
    // ----------------------------------------
    chk_event_all: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (event_in != 7'h00) |=> (raw & $past(event_in)) == $past(event_in))
        else $error("event source not latched");
    chk_raw_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !wr_clear |=> (raw & $past(raw)) == $past(raw))
        else $error("raw status dropped without clear");
    chk_clear_mask: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (wr_clear && (wmask & event_in) == 7'h00) |=> (raw & $past(wmask)) == 7'h00)
        else $error("selected sources not cleared");
    chk_clear_others: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_clear |=> (raw | $past(wmask)) == ($past(raw) | $past(wmask) | $past(event_in)))
        else $error("clear changed unselected sources");
    chk_enset_or: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_enset |=> enable == ($past(enable) | $past(wmask)))
        else $error("enable set mask misapplied");
    chk_enclr_and: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_enclr |=> enable == ($past(enable) & ~$past(wmask)))
        else $error("enable clear mask misapplied");
    chk_enable_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !(wr_enable || wr_enset || wr_enclr) |=> $stable(enable))
        else $error("enable mask changed without a write");
    chk_irq_quiet: assert property (@(posedge ref_clk) disable iff (!reset_n)
        ((raw & enable) == 7'h00) |-> !sys_irq)
        else $error("interrupt without enabled asserted source");

    // ----------------------------------------
    // Port select, regulator and clock gating
    // ----------------------------------------
    chk_legacy_bus: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (wr_port && !req.wdata[1]) |=> !port_fast_bus[1])
        else $error("cleared select left port on fast bus");
    chk_port_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !wr_port |=> $stable(port_fast_bus))
        else $error("port bus select changed without a write");
    chk_reg_write: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (wr_reg && reg_ok) |=> regulator_setting == $past(reg_code))
        else $error("regulator code not stored");
    chk_reg_refuse: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (wr_reg && !reg_ok) |=> $stable(regulator_setting))
        else $error("out of range regulator code taken");
    chk_reg_hold: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !wr_reg |=> $stable(regulator_setting))
        else $error("regulator changed without a write");
    chk_gate_store: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_gate |=> gate_on == $past(req.wdata[0]))
        else $error("gating bit not stored");
    chk_gate_run: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (mode == sce_pkg::SCE_RUN) |=> periph_clock_en == $past(run_clock_en))
        else $error("run mode clocks gated");
    chk_gate_sleep: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (gate_on && mode == sce_pkg::SCE_SLEEP) |=> periph_clock_en == $past(run_clock_en & sleep_mask))
        else $error("sleep clocks ignore sleep mask");
    chk_gate_deep: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (gate_on && mode == sce_pkg::SCE_DEEP) |=> periph_clock_en == $past(run_clock_en & deep_mask))
        else $error("deep-sleep clocks ignore deep mask");
    chk_sleep_store: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_sleep |=> sleep_mask == $past(req.wdata[PERIPHS-1:0]))
        else $error("sleep mask not stored");
    chk_deep_store: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_deep |=> deep_mask == $past(req.wdata[PERIPHS-1:0]))
        else $error("deep-sleep mask not stored");
    chk_sleep_keep: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !wr_sleep |=> $stable(sleep_mask))
        else $error("sleep mask lost its value");
    chk_deep_keep: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !wr_deep |=> $stable(deep_mask))
        else $error("deep-sleep mask lost its value");
endmodule : sce_top

// *** bench/testbench.sv ***
// Self-checking bench for the system-control event and gating block.
// Assumes sce_top with its APB slave answering after one wait state.
`timescale 1ns/100ps
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("BAD %0t got %h exp %h", $time, (got), (exp)); end end
module testbench;
    // ----------------------------------------
    // Stimulus and design hookup
    // ----------------------------------------
    localparam logic [31:0] FLASH = 32'h0002_0000;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0;
    logic [6:0]  event_in = 7'h00;
    logic [1:0]  power_mode = 2'h0;
    logic [31:0] run_clock_en = 32'hffff_0f0f;
    logic        pready, pslverr, sys_irq;
    logic [31:0] prdata, periph_clock_en, rdat;
    logic [7:0]  port_fast_bus;
    logic [3:0]  regulator_setting;
    logic        rerr;
    int          n_mismatch = 0;
    int          n_tests    = 0;

    sce_top #(.PORTS(8), .PERIPHS(32), .FLASH_BYTES(FLASH)) sce_top_i (
        .ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .event_in(event_in), .power_mode(power_mode), .run_clock_en(run_clock_en), .sys_irq(sys_irq),
        .port_fast_bus(port_fast_bus), .regulator_setting(regulator_setting),
        .periph_clock_en(periph_clock_en));

    initial
    begin
        forever #50 ref_clk = ~ref_clk;
    end

    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        `CHK(rdat, exp)
    endtask : rd

    task automatic settle();
        repeat (2) @(posedge ref_clk);
    endtask : settle

    task automatic give_verdict();
        $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict

    initial
    begin
        repeat (5000) @(posedge ref_clk);
        n_mismatch++;
        give_verdict();
    end

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        repeat (10) @(posedge ref_clk);
        reset_n <= 1'b1;
        rd(sce_pkg::REG_OFS, 32'h5);
        rd(sce_pkg::ENABLE_OFS, 32'h0);
        $display("test reset done");
        // Sticky events raised with every source disabled
        @(posedge ref_clk) event_in <= 7'h7f;
        @(posedge ref_clk) event_in <= 7'h00;
        rd(sce_pkg::RAW_OFS, 32'h7f);
        rd(sce_pkg::MASKED_OFS, 32'h0);
        `CHK(sys_irq, 1'b0)
        wr(sce_pkg::ENSET_OFS, 32'h5);
        wr(sce_pkg::ENSET_OFS, 32'h2);
        rd(sce_pkg::ENABLE_OFS, 32'h7);
        rd(sce_pkg::MASKED_OFS, 32'h7);
        `CHK(sys_irq, 1'b1)
        wr(sce_pkg::CLEAR_OFS, 32'h3);
        rd(sce_pkg::RAW_OFS, 32'h7c);
        rd(sce_pkg::MASKED_OFS, 32'h4);
        `CHK(sys_irq, 1'b1)
        wr(sce_pkg::ENCLR_OFS, 32'h4);
        settle();
        `CHK(sys_irq, 1'b0)
        rd(sce_pkg::ENABLE_OFS, 32'h3);
        wr(sce_pkg::CLEAR_OFS, 32'h7f);
        rd(sce_pkg::RAW_OFS, 32'h0);
        wr(sce_pkg::ENABLE_OFS, 32'h41);
        rd(sce_pkg::ENABLE_OFS, 32'h41);
        `CHK(rerr, 1'b0)
        $display("test events done");
        wr(sce_pkg::PORTBUS_OFS, 32'ha5);
        settle();
        `CHK(port_fast_bus, 8'ha5)
        wr(sce_pkg::PORTBUS_OFS, 32'h21);
        settle();
        `CHK(port_fast_bus, 8'h21)
        $display("test port bus done");
        wr(sce_pkg::REG_OFS, 32'ha);
        rd(sce_pkg::REG_OFS, 32'ha);
        `CHK(regulator_setting, 4'ha)
        wr(sce_pkg::REG_OFS, 32'h0);
        wr(sce_pkg::REG_OFS, 32'hb);
        rd(sce_pkg::REG_OFS, 32'h0);
        $display("test regulator done");
        wr(sce_pkg::SLEEP_OFS, 32'h0000_00ff);
        wr(sce_pkg::DEEP_OFS, 32'hff00_0000);
        for (int g = 0; g < 2; g++)
        begin
            wr(sce_pkg::GATE_OFS, g);
            for (int m = 0; m < 4; m++)
            begin
                @(posedge ref_clk) power_mode <= 2'(m);
                settle();
                `CHK(periph_clock_en, (g == 0 || m == 0 || m == 3) ? run_clock_en :
                     run_clock_en & (m == 1 ? 32'h0000_00ff : 32'hff00_0000))
            end
        end
        wr(sce_pkg::GATE_OFS, 32'h0);
        rd(sce_pkg::SLEEP_OFS, 32'h0000_00ff);
        rd(sce_pkg::DEEP_OFS, 32'hff00_0000);
        $display("test gating done");
        rd(sce_pkg::FLASH_OFS, FLASH);
        wr(sce_pkg::FLASH_OFS, 32'h1);
        `CHK(rerr, 1'b1)
        rd(sce_pkg::FLASH_OFS, FLASH);
        rd(12'h100, 32'h0);
        `CHK(rerr, 1'b1)
        $display("test flash and errors done");
        give_verdict();
    end
endmodule : testbench
